// ===== core/ldf_map.svh
// register offsets, bit positions and timing counts for the diagnostic flags
`ifndef LDF_MAP_SVH
`define LDF_MAP_SVH
`define LDF_ADDR_BOOT        8'h34
`define LDF_ADDR_HEADROOM    8'h35
`define LDF_ADDR_MEMTOG      8'h36
`define LDF_ADDR_COPY        8'h06
`define LDF_BIT_TOG_ONE      0
`define LDF_BIT_TOG_TWO      1
`define LDF_BIT_MEM_DONE     3
`define LDF_BIT_MEM_REFUSED  4
`define LDF_BIT_HR_ONE       0
`define LDF_BIT_HR_TWO       1
`define LDF_BIT_HIT_ONE      3
`define LDF_BIT_HIT_TWO      4
`define LDF_BIT_BOOT_ONE     0
`define LDF_BIT_BOOT_TWO     1
`define LDF_CLK_MHZ          40
`define LDF_GATE_HIGH_US     1000
`define LDF_GATE_HIGH_CYCLES (`LDF_GATE_HIGH_US * `LDF_CLK_MHZ)
`endif

// ===== core/ldf_pkg.sv
// types shared by the diagnostic flag logic
package ldf_pkg;
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } ldf_wr_t;

    typedef struct packed {
        logic [1:0] on;
        logic [1:0] headroom_low;
        logic [1:0] headroom_ok;
        logic [1:0] target_hit;
        logic [1:0] gate_high;
        logic [1:0] boot_cap_low;
        logic       mem_refused;
        logic       mem_done;
    } ldf_cond_t;

    typedef struct packed {
        logic [7:0] boot;
        logic [7:0] headroom;
        logic [7:0] memtog;
    } ldf_regs_t;
endpackage : ldf_pkg

// ===== core/ldf_gate_timer.sv
// counts how long one channel's gate stays high while dimming is high
`timescale 1ns/1ps
`include "ldf_map.svh"
module ldf_gate_timer #(
    parameter int unsigned LIMIT = `LDF_GATE_HIGH_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic gate_high,
    input  wire logic dim_high,
    output logic      expired
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        expired;
    } ldf_tmr_t;

    ldf_tmr_t st_reg;
    ldf_tmr_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.expired = 1'b0;
        if (gate_high && dim_high) begin
            if (st_reg.cnt < LIMIT) begin
                st_next.cnt = st_reg.cnt + 32'h1;
            end
            if (st_reg.cnt == LIMIT - 1) begin
                st_next.expired = 1'b1;
            end
        end else begin
            st_next.cnt = 32'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign expired = st_reg.expired;
endmodule : ldf_gate_timer

// ===== core/ldf_diag_flags.sv
// sticky diagnostic flags of the two-channel led driver
`timescale 1ns/1ps
`include "ldf_map.svh"
module ldf_diag_flags (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [1:0]        dim_pin,
    input  wire logic              supply_good,
    input  wire ldf_pkg::ldf_wr_t  wr,
    input  wire ldf_pkg::ldf_cond_t cond,
    output ldf_pkg::ldf_regs_t     regs,
    output logic [1:0]             gate_block,
    output logic [1:0]             reached_status,
    output logic [1:0]             copy_pending
);
    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] dim_prev;
        logic [1:0] toggled;
        logic       mem_refused;
        logic       mem_done;
        logic [1:0] hr_flag;
        logic [1:0] hr_force;
        logic [1:0] hit;
        logic [1:0] boot_flag;
        logic [1:0] copy_req;
        logic [1:0] reached;
        ldf_pkg::ldf_regs_t regs;
        logic [1:0] gate_block;
        logic [2:0] warm;
    } ldf_state_t;

    ldf_state_t st_reg;
    ldf_state_t st_next;
    logic [1:0] timeout;

    function automatic logic hit_addr(input ldf_pkg::ldf_wr_t w,
                                      input logic [7:0] a);
        hit_addr = w.wr && (w.addr == a);
    endfunction : hit_addr

    // reserved bits read as zero
    function automatic ldf_pkg::ldf_regs_t pack_regs(input ldf_state_t s);
        ldf_pkg::ldf_regs_t r;
        r = '0;
        r.memtog[`LDF_BIT_TOG_ONE]     = s.toggled[0];
        r.memtog[`LDF_BIT_TOG_TWO]     = s.toggled[1];
        r.memtog[`LDF_BIT_MEM_DONE]    = s.mem_done;
        r.memtog[`LDF_BIT_MEM_REFUSED] = s.mem_refused;
        r.headroom[`LDF_BIT_HR_ONE]    = s.hr_flag[0];
        r.headroom[`LDF_BIT_HR_TWO]    = s.hr_flag[1];
        r.headroom[`LDF_BIT_HIT_ONE]   = s.hit[0];
        r.headroom[`LDF_BIT_HIT_TWO]   = s.hit[1];
        r.boot[`LDF_BIT_BOOT_ONE]      = s.boot_flag[0];
        r.boot[`LDF_BIT_BOOT_TWO]      = s.boot_flag[1];
        pack_regs = r;
    endfunction : pack_regs

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_tmr
            ldf_gate_timer u_tmr (
                .clk       (clk),
                .rst       (rst),
                .gate_high (cond.gate_high[g]),
                .dim_high  (st_reg.sync2[g]),
                .expired   (timeout[g])
            );
        end
    endgenerate

    always_comb begin
        logic       wr_mem;
        logic       wr_hr;
        logic       wr_boot;
        logic       wr_copy;
        logic [1:0] dim_fall;
        logic [1:0] dim_chg;
        wr_mem  = hit_addr(wr, `LDF_ADDR_MEMTOG);
        wr_hr   = hit_addr(wr, `LDF_ADDR_HEADROOM);
        wr_boot = hit_addr(wr, `LDF_ADDR_BOOT);
        wr_copy = hit_addr(wr, `LDF_ADDR_COPY);
        // no edges until dim_prev holds a synchronised pin level
        dim_chg  = (st_reg.sync2 ^ st_reg.dim_prev) & {2{st_reg.warm[2]}};
        dim_fall = st_reg.dim_prev & ~st_reg.sync2 & {2{st_reg.warm[2]}};
        st_next = st_reg;
        st_next.warm = {st_reg.warm[1:0], 1'b1};
        st_next.sync1 = dim_pin;
        st_next.sync2 = st_reg.sync1;
        st_next.dim_prev = st_reg.sync2;

        // write clears first, hardware sets afterwards so a set wins
        if (wr_mem) begin
            st_next.mem_refused = 1'b0;
            st_next.mem_done    = 1'b0;
            st_next.toggled     = 2'b00;
        end
        if (cond.mem_refused) begin
            st_next.mem_refused = 1'b1;
        end
        if (cond.mem_done) begin
            st_next.mem_done = 1'b1;
        end
        st_next.toggled = st_next.toggled | dim_chg;

        if (wr_hr) begin
            st_next.hr_flag = 2'b00;
        end
        if (wr_boot) begin
            st_next.boot_flag = st_reg.boot_flag & ~wr.data[1:0];
        end

        for (int i = 0; i < 2; i++) begin
            if (cond.headroom_low[i] && cond.on[i] && supply_good) begin
                st_next.hr_force[i] = 1'b1;
                st_next.hr_flag[i]  = 1'b1;
            end else if (cond.headroom_ok[i]) begin
                st_next.hr_force[i] = 1'b0;
            end
            if (!supply_good || dim_fall[i] || st_reg.copy_req[i]
                || timeout[i]) begin
                st_next.hit[i] = 1'b0;
            end else if (cond.target_hit[i]) begin
                st_next.hit[i] = 1'b1;
            end
            if (!supply_good) begin
                st_next.reached[i] = 1'b0;
            end else if (dim_fall[i] || st_reg.copy_req[i]) begin
                st_next.reached[i] = st_reg.hit[i];
            end
            if (st_reg.copy_req[i]) begin
                st_next.copy_req[i] = 1'b0;
            end
            if (cond.boot_cap_low[i]) begin
                st_next.boot_flag[i] = 1'b1;
            end
        end

        // a new request outranks the self-clear of a served one
        if (wr_copy) begin
            st_next.copy_req = st_next.copy_req | wr.data[1:0];
        end

        // boot flag and hr_force both low let the channel switch again
        st_next.gate_block = st_next.hr_force | st_next.boot_flag;

        st_next.regs = pack_regs(st_next);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign regs           = st_reg.regs;
    assign gate_block     = st_reg.gate_block;
    assign reached_status = st_reg.reached;
    assign copy_pending   = st_reg.copy_req;
endmodule : ldf_diag_flags

// ===== verif/ldf_diag_flags_assertions.sv
// checker of the diagnostic flag behaviour
`timescale 1ns/1ps
module ldf_checker (
    input wire logic               clk,
    input wire logic               rst,
    input wire logic [1:0]         dim_pin,
    input wire logic               supply_good,
    input wire ldf_pkg::ldf_wr_t   wr,
    input wire ldf_pkg::ldf_cond_t cond,
    input wire ldf_pkg::ldf_regs_t regs,
    input wire logic [1:0]         gate_block,
    input wire logic [1:0]         copy_pending
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic w34, w35, w36, w06;
    assign w34 = wr.wr && wr.addr == 8'h34;
    assign w35 = wr.wr && wr.addr == 8'h35;
    assign w36 = wr.wr && wr.addr == 8'h36;
    assign w06 = wr.wr && wr.addr == 8'h06;
    AST_REFUSED: assert property (cond.mem_refused |=> regs.memtog[4])
        else $error("refused flag not set");
    AST_DONE: assert property (cond.mem_done |=> regs.memtog[3])
        else $error("done flag not set");
    AST_MEMCLR: assert property (w36 && !cond.mem_done |=>
        !regs.memtog[3]) else $error("done flag not cleared");
    AST_TOGGLE: assert property ($changed(dim_pin[0]) && !$past(rst)
        ##0 !w36[*5] |-> regs.memtog[0]) else $error("toggle flag not set");
    AST_HEADROOM: assert property (cond.on[0] && supply_good &&
        cond.headroom_low[0] |=> regs.headroom[0] && gate_block[0])
        else $error("headroom event not flagged");
    AST_HRHOLD: assert property (regs.headroom[0] && !w35 |=>
        regs.headroom[0]) else $error("headroom flag lost");
    AST_BOOT: assert property (cond.boot_cap_low[1] |=>
        regs.boot[1] && gate_block[1]) else $error("boot event not flagged");
    AST_BOOTKEEP: assert property (regs.boot[1] && !(w34 && wr.data[1])
        |=> regs.boot[1]) else $error("boot flag lost");
    AST_COPY: assert property (w06 && wr.data[0] |=>
        copy_pending[0] ##1 (!copy_pending[0] || $past(w06 && wr.data[0])))
        else $error("copy not served");
    AST_HRREL: assert property (cond.headroom_ok[0] &&
        !(cond.headroom_low[0] && cond.on[0] && supply_good) |=>
        !gate_block[0] || regs.boot[0]) else $error("gate not released");
    AST_BOOTCLR: assert property (w34 && wr.data[1] &&
        !cond.boot_cap_low[1] |=> !regs.boot[1])
        else $error("boot flag not cleared");
    cover property (w06);
    cover property (regs.boot[1]);
    cover property (regs.memtog[0]);
endmodule : ldf_checker
bind ldf_diag_flags ldf_checker ldf_checker_i (.clk, .rst, .dim_pin,
    .supply_good, .wr, .cond, .regs, .gate_block, .copy_pending);

// ===== verif/ldf_host.sv
// host model that writes one register byte at a time
`timescale 1ns/1ps
module ldf_host (
    input wire logic         clk,
    output ldf_pkg::ldf_wr_t wr
);
    initial wr = '0;
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 wr <= '{1'b1, a, d & 8'h1B};
        @(posedge clk);
        #1 wr <= '0;
    endtask : put
endmodule : ldf_host

// ===== verif/testbench.sv
// self-checking bench of the diagnostic flag registers
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] dim_pin = 2'h0;
    logic supply_good = 1'b1;
    ldf_pkg::ldf_cond_t cond = '0;
    ldf_pkg::ldf_wr_t wr;
    ldf_pkg::ldf_regs_t regs;
    logic [1:0] gb, rs, cp;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    always #12.5 clk = ~clk;
    ldf_host ldf_host_i (.clk, .wr);
    ldf_diag_flags ldf_diag_flags_i (.clk, .rst, .dim_pin, .supply_good,
        .wr, .cond, .regs, .gate_block(gb), .reached_status(rs),
        .copy_pending(cp));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic check(input string s, input logic [7:0] v, e);
        n_checks++;
        if (v !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", s, e, v);
        end
    endtask : check
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    task automatic t_memtog;
        dim_pin = 2'h3;
        cond.mem_refused = 1'b1;
        cond.mem_done = 1'b1;
        tick(1);
        cond.mem_refused = 1'b0;
        cond.mem_done = 1'b0;
        tick(5);
        check("memtog", regs.memtog, 8'h1B);
        ldf_host_i.put(8'h36, 8'h00);
        tick(2);
        check("memtog clr", regs.memtog, 8'h00);
        $display("test memtog done");
    endtask : t_memtog
    task automatic t_head;
        cond.on = 2'h3;
        supply_good = 1'b0;
        cond.headroom_low = 2'h3;
        tick(2);
        check("hr off", regs.headroom, 8'h00);
        supply_good = 1'b1;
        tick(2);
        check("hr set", regs.headroom, 8'h03);
        check("gate", 8'(gb), 8'h03);
        cond.headroom_low = 2'h0;
        cond.headroom_ok = 2'h3;
        tick(2);
        check("gate rel", 8'(gb), 8'h00);
        check("hr hold", regs.headroom, 8'h03);
        ldf_host_i.put(8'h35, 8'h00);
        tick(2);
        check("hr clr", regs.headroom, 8'h00);
        $display("test headroom done");
    endtask : t_head
    task automatic t_hit;
        cond.target_hit = 2'h3;
        tick(1);
        cond.target_hit = 2'h0;
        tick(2);
        check("hit", regs.headroom, 8'h18);
        ldf_host_i.put(8'h06, 8'h01);
        check("pend", 8'(cp), 8'h01);
        tick(2);
        check("copy", regs.headroom, 8'h10);
        check("reached", 8'(rs), 8'h01);
        check("pend gone", 8'(cp), 8'h00);
        dim_pin = 2'h1;
        tick(6);
        check("dim fall", regs.headroom, 8'h00);
        $display("test hit done");
    endtask : t_hit
    task automatic t_boot;
        cond.boot_cap_low = 2'h3;
        tick(1);
        cond.boot_cap_low = 2'h0;
        tick(2);
        check("boot", regs.boot, 8'h03);
        ldf_host_i.put(8'h34, 8'h00);
        ldf_host_i.put(8'h34, 8'h02);
        tick(2);
        check("boot one", regs.boot, 8'h01);
        check("gate one", 8'(gb), 8'h01);
        ldf_host_i.put(8'h20, 8'h03);
        tick(2);
        check("unmapped", regs.boot, 8'h01);
        $display("test boot done");
    endtask : t_boot
    initial begin
        tick(8);
        rst = 1'b0;
        tick(1);
        t_memtog;
        t_head;
        t_hit;
        t_boot;
        results;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            results;
        end
    end
endmodule : testbench
